// >>> logic/asmr_pkg.sv
// Constants, types and carriers of the ADC status and mode register block.
package asmr_pkg;

  // ==========================================================
  // Register select codes and reset values
  localparam logic [2:0] SEL_COMM_STATUS = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [15:0] MODE_RESET = 16'h000a;
  localparam logic [15:0] MODE_KEEP_MASK = 16'he0cf;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h0;

  // ==========================================================
  // Communications byte field positions
  localparam int unsigned COMM_WEN_BIT = 7;
  localparam int unsigned COMM_RW_BIT = 6;
  localparam int unsigned COMM_SEL_MSB = 5;
  localparam int unsigned COMM_SEL_LSB = 3;

  // ==========================================================
  // Last bit index of each transfer, counted in serial clocks
  localparam logic [3:0] COMM_LAST = 4'h7;
  localparam logic [3:0] STATUS_LAST = 4'h7;
  localparam logic [3:0] MODE_LAST = 4'hf;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_COMM = 2'b00,
    ST_RD_STAT = 2'b01,
    ST_RD_MODE = 2'b10,
    ST_WR_MODE = 2'b11
  } asmr_state_t;

  typedef struct packed {
    logic [2:0] operating_mode_field;
    logic [4:0] reserved_hi;
    logic [1:0] clock_source_field;
    logic [1:0] reserved_lo;
    logic [3:0] update_rate_field;
  } asmr_mode_t;

  typedef struct packed {
    logic ready;
    logic error;
    logic [1:0] zero_bits;
    logic resolution_variant_bit;
    logic [2:0] active_input_code;
  } asmr_status_t;

  typedef struct packed {
    logic result_write;
    logic clamped;
    logic pre_update;
    logic data_read;
    logic [2:0] active_input_code;
  } asmr_conv_evt_t;

endpackage

// >>> logic/asmr_shifter.sv
// Sixteen-bit shift register that serves both serial read-out and write assembly.
`timescale 1ns/1ps
module asmr_shifter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [WIDTH-1:0] word_o,
  output logic msb_o
);

  logic [WIDTH-1:0] word_reg;
  logic [WIDTH-1:0] word_next;

  // ==========================================================
  // Next value
  // A load takes priority, so a new transfer never inherits old bits.
  always_comb begin
    word_next = word_reg;
    if (load_i) begin
      word_next = load_val_i;
    end else if (shift_i) begin
      word_next = {word_reg[WIDTH-2:0], bit_i};
    end
  end

  // ==========================================================
  // Storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign word_o = word_reg;
  assign msb_o = word_reg[WIDTH-1];

endmodule

// >>> logic/asmr_top.sv
// Status and mode registers of the ADC, reached over its three-wire serial port.
`timescale 1ns/1ps
module asmr_top #(
  parameter logic RESOLUTION_24 = 1'b0,
  parameter logic [2:0] PWRDN_CODE = 3'h3
) (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic DIN_I,
  input wire asmr_pkg::asmr_conv_evt_t CONV_I,
  output logic DOUT_RDY_O,
  output logic DOUT_OE_O,
  output asmr_pkg::asmr_mode_t MODE_O,
  output asmr_pkg::asmr_status_t STATUS_O,
  output logic FILTER_RESET_O,
  output logic POWER_DOWN_O
);
  import asmr_pkg::*;

  // ==========================================================
  // Helpers

  function automatic logic at_last(input logic [3:0] cnt, input logic [3:0] last);
    at_last = (cnt == last);
  endfunction

  function automatic logic [3:0] cnt_step(input logic [3:0] cnt);
    cnt_step = cnt + 4'h1;
  endfunction

  function automatic logic is_pwrdn(input logic [2:0] field);
    is_pwrdn = (field == PWRDN_CODE);
  endfunction

  function automatic logic is_read_state(input asmr_state_t st);
    is_read_state = (st == ST_RD_STAT) || (st == ST_RD_MODE);
  endfunction

  // ==========================================================
  // Declarations

  logic sclk_q_reg;
  logic sclk_q_next;
  logic sclk_rise;

  asmr_state_t state_reg;
  asmr_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] comm_reg;
  logic [7:0] comm_next;

  logic [7:0] comm_full;
  logic comm_rd;
  logic [2:0] comm_sel;

  logic sh_load;
  logic [15:0] sh_val;
  logic sh_shift;
  logic [15:0] sh_word;
  logic sh_msb;
  logic [15:0] wr_word;
  logic mode_wr;

  asmr_status_t status_reg;
  asmr_status_t status_next;
  asmr_mode_t mode_reg;
  asmr_mode_t mode_next;

  logic filt_rst_reg;
  logic filt_rst_next;
  logic pwrdn_reg;
  logic pwrdn_next;
  logic dout_reg;
  logic dout_next;
  logic oe_reg;
  logic oe_next;

  logic ready_set;
  logic ready_clr;
  logic err_load;
  logic err_clr;

  // ==========================================================
  // Serial clock edge detection
  // The serial clock is sampled on the system clock, so it must run well
  // below the system clock rate; each rising edge is seen exactly once.

  always_comb begin
    sclk_q_next = SCLK_I;
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sclk_q_reg <= 1'b1;
    end else begin
      sclk_q_reg <= sclk_q_next;
    end
  end

  assign sclk_rise = SCLK_I & ~sclk_q_reg;

  // ==========================================================
  // Communications byte decode

  assign comm_full = {comm_reg[6:0], DIN_I};
  assign comm_rd = comm_full[COMM_RW_BIT];
  assign comm_sel = comm_full[COMM_SEL_MSB:COMM_SEL_LSB];
  assign wr_word = {sh_word[14:0], DIN_I};

  // ==========================================================
  // Transfer sequencer
  // Every transfer starts with a communications byte. Its first bit must
  // be zero; a one there is ignored and the port waits at that bit.
  // Select codes other than status and mode belong to other register
  // blocks, so this port just returns to waiting for a command.

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    comm_next = comm_reg;
    sh_load = 1'b0;
    sh_val = '0;
    sh_shift = 1'b0;
    mode_wr = 1'b0;
    if (CS_N_I) begin
      state_next = ST_COMM;
      cnt_next = CNT_ZERO;
    end else if (sclk_rise) begin
      unique case (state_reg)
        ST_COMM: begin
          if ((cnt_reg == CNT_ZERO) && DIN_I) begin
            cnt_next = CNT_ZERO;
          end else if (at_last(cnt_reg, COMM_LAST)) begin
            cnt_next = CNT_ZERO;
            if (comm_rd && (comm_sel == SEL_COMM_STATUS)) begin
              state_next = ST_RD_STAT;
              sh_load = 1'b1;
              sh_val = {status_reg, 8'h00};
            end else if (comm_rd && (comm_sel == SEL_MODE)) begin
              state_next = ST_RD_MODE;
              sh_load = 1'b1;
              sh_val = mode_reg;
            end else if (!comm_rd && (comm_sel == SEL_MODE)) begin
              state_next = ST_WR_MODE;
            end else begin
              state_next = ST_COMM;
            end
            comm_next = comm_full;
          end else begin
            cnt_next = cnt_step(cnt_reg);
            comm_next = comm_full;
          end
        end
        ST_RD_STAT: begin
          sh_shift = 1'b1;
          if (at_last(cnt_reg, STATUS_LAST)) begin
            state_next = ST_COMM;
            cnt_next = CNT_ZERO;
          end else begin
            cnt_next = cnt_step(cnt_reg);
          end
        end
        ST_RD_MODE: begin
          sh_shift = 1'b1;
          if (at_last(cnt_reg, MODE_LAST)) begin
            state_next = ST_COMM;
            cnt_next = CNT_ZERO;
          end else begin
            cnt_next = cnt_step(cnt_reg);
          end
        end
        ST_WR_MODE: begin
          sh_shift = 1'b1;
          if (at_last(cnt_reg, MODE_LAST)) begin
            state_next = ST_COMM;
            cnt_next = CNT_ZERO;
            mode_wr = 1'b1;
          end else begin
            cnt_next = cnt_step(cnt_reg);
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= ST_COMM;
      cnt_reg <= CNT_ZERO;
      comm_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      comm_reg <= comm_next;
    end
  end

  // ==========================================================
  // Shared shift register
  // One register carries read data out and write data in, since a
  // transfer is only ever one or the other.

  asmr_shifter #(
    .WIDTH(16)
  ) u_shifter (
    .clk_i(MCLK_I),
    .rst_n_i(NRST_I),
    .load_i(sh_load),
    .load_val_i(sh_val),
    .shift_i(sh_shift),
    .bit_i(DIN_I),
    .word_o(sh_word),
    .msb_o(sh_msb)
  );

  // ==========================================================
  // Flag events
  // Every event that moves ready or error is decoded here, so the
  // set-over-clear priority of the status register sits in one place.
  // A power-down write sets ready on its own account, so the flag stays
  // right even if the plain write side effect is ever narrowed.

  always_comb begin
    ready_clr = CONV_I.result_write;
    ready_set = CONV_I.data_read || CONV_I.pre_update;
    err_load = CONV_I.result_write;
    err_clr = 1'b0;
    if (mode_wr) begin
      ready_set = 1'b1;
      err_clr = 1'b1;
    end
    if (mode_wr && is_pwrdn(wr_word[15:13])) begin
      ready_set = 1'b1;
    end
  end

  // ==========================================================
  // Status register
  // No serial write reaches this register, and reading it only copies it
  // into the shift register, so reads leave the flags alone.

  always_comb begin
    status_next = status_reg;
    status_next.zero_bits = 2'h0;
    status_next.resolution_variant_bit = RESOLUTION_24;
    status_next.active_input_code = CONV_I.active_input_code;
    // A result and a set event in the same cycle leave ready set, so the
    // host is never told to read data that is about to change.
    if (err_load) begin
      status_next.error = CONV_I.clamped;
    end else if (err_clr) begin
      status_next.error = 1'b0;
    end
    if (ready_clr) begin
      status_next.ready = 1'b0;
    end
    if (ready_set) begin
      status_next.ready = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==========================================================
  // Mode register
  // Reserved bits are dropped on write, so a host that breaks the
  // zero-write convention still reads back only the defined fields.

  always_comb begin
    mode_next = mode_reg;
    if (mode_wr) begin
      mode_next = wr_word & MODE_KEEP_MASK;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_reg <= MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // Conversion path controls

  always_comb begin
    filt_rst_next = mode_wr;
    pwrdn_next = is_pwrdn(mode_next.operating_mode_field);
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      filt_rst_reg <= 1'b0;
      pwrdn_reg <= 1'b0;
    end else begin
      filt_rst_reg <= filt_rst_next;
      pwrdn_reg <= pwrdn_next;
    end
  end

  // ==========================================================
  // Serial output pin
  // Outside a read the pin shows the ready flag, so a host may poll the
  // pin instead of reading status. Data lags a rising serial edge by two
  // system clocks, which the host sees well before its next rising edge.

  always_comb begin
    if (is_read_state(state_reg)) begin
      dout_next = sh_msb;
    end else begin
      dout_next = status_reg.ready;
    end
    oe_next = ~CS_N_I;
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  // ==========================================================
  // Outputs

  assign DOUT_RDY_O = dout_reg;
  assign DOUT_OE_O = oe_reg;
  assign MODE_O = mode_reg;
  assign STATUS_O = status_reg;
  assign FILTER_RESET_O = filt_rst_reg;
  assign POWER_DOWN_O = pwrdn_reg;

endmodule

// >>> test/asmr_chk_sva.sv
// Assertion checker for the status and mode register block.
`timescale 1ns/1ps
module asmr_chk
  import asmr_pkg::*;
#(
  parameter logic RESOLUTION_24 = 1'b0,
  parameter logic [2:0] PWRDN_CODE = 3'h3
) (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic DIN_I,
  input wire asmr_pkg::asmr_conv_evt_t CONV_I,
  input wire logic DOUT_RDY_O,
  input wire logic DOUT_OE_O,
  input wire asmr_pkg::asmr_mode_t MODE_O,
  input wire asmr_pkg::asmr_status_t STATUS_O,
  input wire logic FILTER_RESET_O,
  input wire logic POWER_DOWN_O
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);

  // The pin is only checked against ready once the port has been deselected long enough to drain.
  sequence s_idle3;
    CS_N_I [*3];
  endsequence
  sequence s_ready_evt;
    CONV_I.data_read || CONV_I.pre_update;
  endsequence

  chk_zero_bits: assert property (STATUS_O.zero_bits == 2'h0)
    else $error("Status bits 5 and 4 not zero.");
  chk_variant_bit: assert property ($past(NRST_I) |->
    STATUS_O.resolution_variant_bit == RESOLUTION_24)
    else $error("Variant bit wrong.");
  chk_ready_clear: assert property (CONV_I.result_write && !CONV_I.pre_update &&
    !CONV_I.data_read |=> !STATUS_O.ready || FILTER_RESET_O)
    else $error("Ready not cleared by a new result.");
  chk_error_load: assert property (CONV_I.result_write |=>
    STATUS_O.error == $past(CONV_I.clamped))
    else $error("Error flag not loaded with the result.");
  chk_ready_set: assert property (s_ready_evt |=> STATUS_O.ready)
    else $error("Ready not set.");
  chk_write_effect: assert property (FILTER_RESET_O |-> STATUS_O.ready &&
    (!STATUS_O.error || $past(CONV_I.result_write)) ##1 !FILTER_RESET_O)
    else $error("Mode write effect wrong.");
  chk_pin_mirror: assert property (s_idle3 |-> DOUT_RDY_O == $past(STATUS_O.ready))
    else $error("Pin does not mirror ready.");
  chk_pd_decode: assert property (POWER_DOWN_O ==
    (MODE_O.operating_mode_field == PWRDN_CODE))
    else $error("Power-down decode wrong.");
  chk_pd_ready: assert property ($rose(POWER_DOWN_O) |-> STATUS_O.ready)
    else $error("Ready not set on power-down.");
  chk_reserved_zero: assert property ((MODE_O & ~MODE_KEEP_MASK) == 16'h0)
    else $error("Reserved mode bits not zero.");
  chk_mode_hold: assert property (!$stable(MODE_O) |-> FILTER_RESET_O)
    else $error("Mode changed without a write.");
  // The first edge after reset release still shows the reset channel code.
  chk_channel: assert property ($past(NRST_I) |->
    STATUS_O.active_input_code == $past(CONV_I.active_input_code))
    else $error("Channel code not followed.");
  chk_oe_follow: assert property ($past(NRST_I) |-> DOUT_OE_O == !$past(CS_N_I))
    else $error("Output enable does not follow chip select.");
  cov_mode_write: cover property (FILTER_RESET_O);
endmodule

bind asmr_top asmr_chk #(.RESOLUTION_24(RESOLUTION_24), .PWRDN_CODE(PWRDN_CODE)) i_asmr_chk (
  .MCLK_I, .NRST_I, .SCLK_I, .CS_N_I, .DIN_I, .CONV_I, .DOUT_RDY_O, .DOUT_OE_O, .MODE_O,
  .STATUS_O, .FILTER_RESET_O, .POWER_DOWN_O);

// >>> test/asmr_host_model.sv
// Behavioural host controller that drives the serial port of the register block.
`timescale 1ns/1ps
module asmr_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // ==========================================================
  // Serial transfers
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  // Each phase lasts four clocks, two above the minimum, so read data is settled when sampled.
  task automatic send_bit(input logic b, output logic r);
    @(posedge clk_i) sclk_o <= 1'b0;
    din_o <= b;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) r = dout_i;
    @(posedge clk_i) sclk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic xfer(input logic [7:0] comm, input logic [15:0] wd, input int n,
                      output logic [15:0] rd);
    logic r;
    logic [15:0] w;
    w = wd;
    rd = 16'h0;
    if (comm[5:3] == 3'h1 && !comm[6]) w[12:8] = 5'h0;
    @(posedge clk_i) cs_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) send_bit(comm[i], r);
    for (int i = n - 1; i >= 0; i--) begin
      send_bit(w[i], r);
      rd = {rd[14:0], r};
    end
    @(posedge clk_i) cs_n_o <= 1'b1;
    din_o <= ~din_o;
  endtask
endmodule

// >>> test/asmr_top_tb_top.sv
// Self-checking testbench of the status and mode register block.
`timescale 1ns/1ps
module asmr_top_tb_top;
  import asmr_pkg::*;
  logic mclk;
  logic nrst;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic oe;
  logic filt;
  logic pd;
  asmr_conv_evt_t conv;
  asmr_mode_t mode;
  asmr_status_t stat;
  logic [15:0] rd;
  int error_cnt;
  int checks;

  asmr_top i_asmr_top (.MCLK_I(mclk), .NRST_I(nrst), .SCLK_I(sclk), .CS_N_I(cs_n),
    .DIN_I(din), .CONV_I(conv), .DOUT_RDY_O(dout), .DOUT_OE_O(oe), .MODE_O(mode),
    .STATUS_O(stat), .FILTER_RESET_O(filt), .POWER_DOWN_O(pd));
  asmr_host_model i_asmr_host_model (.clk_i(mclk), .dout_i(dout), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));

  // ==========================================================
  // Helpers
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Mismatches %0d, checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Event pulses last one clock; the channel code stays as a level.
  task automatic pulse(input logic [6:0] ev);
    @(posedge mclk) conv <= ev;
    @(posedge mclk) conv <= ev & 7'h07;
    repeat (3) @(posedge mclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("status", {8'h0, stat}, 16'h0080);
    check("mode", mode, 16'h000a);
    check("pin", {15'h0, dout}, 16'h1);
    check("oe", {15'h0, oe}, 16'h0);
    i_asmr_host_model.xfer(8'h48, 16'h0, 16, rd);
    check("mode read", rd, 16'h000a);
    i_asmr_host_model.xfer(8'h40, 16'h0, 8, rd);
    check("status read", rd, 16'h0080);
  endtask

  task automatic t_events();
    pulse(7'h65);
    check("status", {8'h0, stat}, 16'h0045);
    check("pin", {15'h0, dout}, 16'h0);
    i_asmr_host_model.xfer(8'h40, 16'h0, 8, rd);
    check("status read", rd, 16'h0045);
    check("status after read", {8'h0, stat}, 16'h0045);
    pulse(7'h0d);
    check("ready", {15'h0, stat.ready}, 16'h1);
    pulse(7'h45);
    check("ready", {15'h0, stat.ready}, 16'h0);
    pulse(7'h15);
    check("ready", {15'h0, stat.ready}, 16'h1);
  endtask

  task automatic t_status_write();
    pulse(7'h65);
    i_asmr_host_model.xfer(8'h00, 16'h0, 0, rd);
    repeat (3) @(posedge mclk);
    check("status", {8'h0, stat}, 16'h0045);
    // Another select code ends after its command; the ones that follow are ignored.
    i_asmr_host_model.xfer(8'h10, 16'hffff, 16, rd);
    check("mode", mode, 16'h000a);
    check("status", {8'h0, stat}, 16'h0045);
  endtask

  task automatic t_mode_write();
    pulse(7'h65);
    i_asmr_host_model.xfer(8'h08, 16'he0cf, 16, rd);
    check("mode", mode, 16'he0cf);
    check("flags", {14'h0, stat.ready, stat.error}, 16'h2);
    i_asmr_host_model.xfer(8'h48, 16'h0, 16, rd);
    check("mode read", rd, 16'he0cf);
    pulse(7'h45);
    i_asmr_host_model.xfer(8'h08, 16'h600a, 16, rd);
    check("power down", {15'h0, pd}, 16'h1);
    check("ready", {15'h0, stat.ready}, 16'h1);
    i_asmr_host_model.xfer(8'h08, 16'h000a, 16, rd);
    check("mode", mode, 16'h000a);
    check("power down", {15'h0, pd}, 16'h0);
  endtask

  // A reset in mid-run must restore the defaults, and the channel code is followed again once reset is released.
  task automatic t_mid_reset();
    i_asmr_host_model.xfer(8'h08, 16'h20c5, 16, rd);
    check("mode", mode, 16'h20c5);
    pulse(7'h65);
    @(posedge mclk) nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("mode", mode, 16'h000a);
    check("status", {8'h0, stat}, 16'h0080);
    check("pin", {15'h0, dout}, 16'h1);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    check("status", {8'h0, stat}, 16'h0085);
    i_asmr_host_model.xfer(8'h48, 16'h0, 16, rd);
    check("mode read", rd, 16'h000a);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    nrst = 1'b0;
    conv = '0;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_events();
    t_status_write();
    t_mode_write();
    t_mid_reset();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
